// file: src/pfs_fault_select.sv
// Source select register bank for the second modulator's protection paths.
`include "pfs_defines.svh"

module pfs_fault_select (
   // Clock and reset.
   input  logic                 clk_sys,
   input  logic                 rst_b,
   // APB slave.
   input  logic                 psel,
   input  logic                 penable,
   input  logic                 pwrite,
   input  logic [31:0]          paddr,
   input  logic [31:0]          pwdata,
   input  logic [3:0]           pstrb,
   output logic                 pready,
   output logic [31:0]          prdata,
   output logic                 pslverr,
   // Protection sources.
   input  pfs_pkg::pfs_sources_t sources,
   // Combined results to the modulator.
   output logic                 currentLimitTrigger,
   output logic                 faultAbTrigger,
   // Interrupt.
   output logic                 irq
);

   // ============================================================
   // Helper functions.

   // Address compare, shared by the write and read decoders.
   function automatic logic is_addr(input logic [31:0] addr, input logic [31:0] target);
      is_addr = (addr == target);
   endfunction : is_addr

   // True for every address that this bank answers.
   function automatic logic addr_mapped(input logic [31:0] addr);
      addr_mapped = is_addr(addr, `PFS_ADDR_CLIM)       |
                    is_addr(addr, `PFS_ADDR_FAULT)      |
                    is_addr(addr, `PFS_ADDR_IRQ_STATUS) |
                    is_addr(addr, `PFS_ADDR_IRQ_CLEAR)  |
                    is_addr(addr, `PFS_ADDR_IRQ_ENABLE) |
                    is_addr(addr, `PFS_ADDR_LIVE);
   endfunction : addr_mapped

   // Byte lane merge: only lanes with a strobe take the new write data.
   function automatic logic [31:0] merge_lanes(input logic [31:0] oldWord,
                                               input logic [31:0] newWord,
                                               input logic [3:0]  strb);
      logic [31:0] merged;
      merged = oldWord;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merged[i*8 +: 8] = newWord[i*8 +: 8];
         end
      end
      merge_lanes = merged;
   endfunction : merge_lanes

   // ============================================================
   // State and internal signals.
   pfs_pkg::pfs_regs_state_t stReg;
   pfs_pkg::pfs_regs_state_t stNext;

   logic                        setupPhase;
   logic                        accessDone;
   logic                        writeDone;
   logic [31:0]                 climMerged;
   logic [31:0]                 faultMerged;
   logic [31:0]                 readWord;
   logic [`PFS_CLIM_W-1:0]      sourceVec;
   logic                        climEvent;
   logic                        faultEvent;
   logic [`PFS_EVT_W-1:0]       eventVec;
   logic [`PFS_EVT_W-1:0]       irqStatus;
   logic [`PFS_EVT_W-1:0]       irqEnable;
   logic                        irqEnableWrite;
   logic                        irqClearWrite;
   logic                        climHit;
   logic                        faultHit;

   // ============================================================
   // Bus phase decode.

   // The slave answers in the first access cycle, since pready is set during setup.
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & stReg.preadyReg;
   assign writeDone  = accessDone & pwrite;

   // Sources are packed in select bit order, so one AND serves both gates.
   assign sourceVec  = sources;

   // Merge write data into the current value of each select register.
   assign climMerged  = merge_lanes({16'h0000, stReg.climReg}, pwdata, pstrb);
   assign faultMerged = merge_lanes({17'h0_0000, stReg.faultReg}, pwdata, pstrb);

   // Interrupt register strobes fire on the completing edge of a write.
   assign irqEnableWrite = writeDone & pstrb[0] & is_addr(paddr, `PFS_ADDR_IRQ_ENABLE);
   assign irqClearWrite  = writeDone & pstrb[0] & is_addr(paddr, `PFS_ADDR_IRQ_CLEAR);

   // Each rising trigger becomes one sticky interrupt event.
   assign eventVec[`PFS_EVT_CLIM]  = climEvent;
   assign eventVec[`PFS_EVT_FAULT] = faultEvent;

   // Unselected and reserved bits read as zero; the clear register reads zero.
   always_comb begin
      readWord = 32'h0000_0000;
      if (is_addr(paddr, `PFS_ADDR_CLIM)) begin
         readWord[`PFS_CLIM_W-1:0] = stReg.climReg;
      end else if (is_addr(paddr, `PFS_ADDR_FAULT)) begin
         readWord[`PFS_FAULT_W-1:0] = stReg.faultReg;
      end else if (is_addr(paddr, `PFS_ADDR_IRQ_STATUS)) begin
         readWord[`PFS_EVT_W-1:0] = irqStatus;
      end else if (is_addr(paddr, `PFS_ADDR_IRQ_ENABLE)) begin
         readWord[`PFS_EVT_W-1:0] = irqEnable;
      end else if (is_addr(paddr, `PFS_ADDR_LIVE)) begin
         readWord[`PFS_EVT_CLIM]  = currentLimitTrigger;
         readWord[`PFS_EVT_FAULT] = faultAbTrigger;
      end
   end

   // ============================================================
   // Register bank next state.

   // Read data is captured at setup, so a status change during the access is
   // seen on the next read; this keeps prdata straight from a flip-flop.
   always_comb begin
      stNext            = stReg;
      stNext.preadyReg  = 1'b0;
      stNext.pslverrReg = 1'b0;
      stNext.prdataReg  = 32'h0000_0000;
      if (setupPhase) begin
         stNext.preadyReg  = 1'b1;
         stNext.pslverrReg = ~addr_mapped(paddr);
         stNext.prdataReg  = pwrite ? 32'h0000_0000 : readWord;
      end
      if (writeDone && is_addr(paddr, `PFS_ADDR_CLIM)) begin
         stNext.climReg = climMerged[`PFS_CLIM_W-1:0];
      end
      if (writeDone && is_addr(paddr, `PFS_ADDR_FAULT)) begin
         // Bit 15 of the write data falls outside the register and is dropped.
         stNext.faultReg = faultMerged[`PFS_FAULT_W-1:0];
      end
   end

   // All select bits clear at reset, so no source reaches either function.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stReg.climReg    <= `PFS_CLIM_RESET;
         stReg.faultReg   <= `PFS_FAULT_RESET;
         stReg.preadyReg  <= 1'b0;
         stReg.pslverrReg <= 1'b0;
         stReg.prdataReg  <= 32'h0000_0000;
      end else begin
         stReg <= stNext;
      end
   end

   assign pready  = stReg.preadyReg;
   assign pslverr = stReg.pslverrReg;
   assign prdata  = stReg.prdataReg;

   // ============================================================
   // Source gating for current limit and Fault AB detection.

   // Current limit takes all sixteen sources, peak current detector included.
   pfs_source_gate #(
      .WIDTH       (`PFS_CLIM_W)
   ) u_clim_gate (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .sources     (sourceVec),
      .selects     (stReg.climReg),
      .trigger     (currentLimitTrigger),
      .risingEvent (climEvent)
   );

   // Fault AB has no peak current input; the top source bit is left out.
   pfs_source_gate #(
      .WIDTH       (`PFS_FAULT_W)
   ) u_fault_gate (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .sources     (sourceVec[`PFS_FAULT_W-1:0]),
      .selects     (stReg.faultReg),
      .trigger     (faultAbTrigger),
      .risingEvent (faultEvent)
   );

   // ============================================================
   // Interrupt controller.
   pfs_irq_ctrl #(
      .N           (`PFS_EVT_W)
   ) u_irq (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .events      (eventVec),
      .enableWrite (irqEnableWrite),
      .clearWrite  (irqClearWrite),
      .writeData   (pwdata[`PFS_EVT_W-1:0]),
      .status      (irqStatus),
      .enable      (irqEnable),
      .irq         (irq)
   );

   // ============================================================
   // Assertions.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Helper terms: whether any selected source is active this cycle.
   assign climHit  = |(sourceVec & stReg.climReg);
   assign faultHit = |(sourceVec[`PFS_FAULT_W-1:0] & stReg.faultReg);

   a_pcm_gate_on: assert property (
      (sources.analogPeak && stReg.climReg[`PFS_PCM_BIT]) |=> currentLimitTrigger)
      else $error("Selected peak current did not raise the current limit.");

   a_pcm_gate_off: assert property (
      (!stReg.climReg[`PFS_PCM_BIT] && !(|(sourceVec[`PFS_CLIM_W-2:0] & stReg.climReg[`PFS_CLIM_W-2:0])))
      |=> !currentLimitTrigger)
      else $error("Peak current raised the current limit while not selected.");

   a_dcomp_clim: assert property (
      (|(sources.digitalComparator & stReg.climReg[`PFS_DCOMP_HI:`PFS_DCOMP_LO])) |=> currentLimitTrigger)
      else $error("Selected digital comparator did not raise the current limit.");

   a_ext_clim: assert property (
      (|(sources.externalFault & stReg.climReg[`PFS_EXT_HI:`PFS_EXT_LO])) |=> currentLimitTrigger)
      else $error("Selected fault pin did not raise the current limit.");

   a_acomp_clim: assert property (
      (|(sources.analogComparator & stReg.climReg[`PFS_ACOMP_HI:`PFS_ACOMP_LO])) |=> currentLimitTrigger)
      else $error("Selected analog comparator did not raise the current limit.");

   a_dcomp_fault: assert property (
      (|(sources.digitalComparator & stReg.faultReg[`PFS_DCOMP_HI:`PFS_DCOMP_LO])) |=> faultAbTrigger)
      else $error("Selected digital comparator did not raise Fault AB.");

   a_ext_fault: assert property (
      (|(sources.externalFault & stReg.faultReg[`PFS_EXT_HI:`PFS_EXT_LO])) |=> faultAbTrigger)
      else $error("Selected fault pin did not raise Fault AB.");

   a_acomp_fault: assert property (
      (|(sources.analogComparator & stReg.faultReg[`PFS_ACOMP_HI:`PFS_ACOMP_LO])) |=> faultAbTrigger)
      else $error("Selected analog comparator did not raise Fault AB.");

   a_clim_reset: assert property (
      (!$past(rst_b)) |-> (stReg.climReg == `PFS_CLIM_RESET && !currentLimitTrigger))
      else $error("Current limit selects not zero after reset.");

   a_fault_reset: assert property (
      (!$past(rst_b)) |-> (stReg.faultReg == `PFS_FAULT_RESET && !faultAbTrigger))
      else $error("Fault AB selects not zero after reset.");

   a_clim_cause: assert property (
      $changed(currentLimitTrigger) |-> (currentLimitTrigger == $past(climHit)))
      else $error("Current limit changed without a matching selected source.");

   a_fault_cause: assert property (
      faultAbTrigger |-> $past(faultHit))
      else $error("Fault AB raised with no selected source active.");

   a_reserved_read: assert property (
      (accessDone && !pwrite && is_addr(paddr, `PFS_ADDR_FAULT)) |-> (prdata[31:`PFS_FAULT_W] == 17'h0_0000))
      else $error("Reserved Fault AB bits did not read zero.");

   a_write_lands: assert property (
      (writeDone && is_addr(paddr, `PFS_ADDR_CLIM) && pstrb == 4'hF)
      |=> (stReg.climReg == $past(pwdata[`PFS_CLIM_W-1:0])))
      else $error("Full write to the current limit selects did not land.");

   a_irq_level: assert property (
      irq |-> (|(irqStatus & irqEnable)))
      else $error("Interrupt high with no enabled status bit.");

   a_pready_next: assert property (
      setupPhase |=> (pready ##1 !pready))
      else $error("Slave did not answer in the first access cycle.");

   // Bus answer, error flag and idle levels of the read path.
   a_mapped_ok: assert property (
      (setupPhase && addr_mapped(paddr)) |=> (pready && !pslverr))
      else $error("Mapped address answered with an error.");

   a_unmapped_err: assert property (
      (setupPhase && !addr_mapped(paddr)) |=> (pready && pslverr && prdata == 32'h0000_0000))
      else $error("Unmapped address did not answer with an error and no data.");

   a_idle_quiet: assert property (
      !pready |-> (prdata == 32'h0000_0000 && !pslverr))
      else $error("Read data or error flag left standing outside the answer.");

   // Writes to the select registers, whole and by lane.
   a_fault_lands: assert property (
      (writeDone && is_addr(paddr, `PFS_ADDR_FAULT) && pstrb == 4'hF)
      |=> (stReg.faultReg == $past(pwdata[`PFS_FAULT_W-1:0])))
      else $error("Full write to the Fault AB selects did not land.");

   a_lane_kept: assert property (
      (writeDone && is_addr(paddr, `PFS_ADDR_CLIM) && !pstrb[1])
      |=> $stable(stReg.climReg[`PFS_CLIM_W-1:8]))
      else $error("Upper limit select byte changed without its strobe.");

   // Events, sticky status and the interrupt level.
   a_clim_event: assert property (
      climEvent == $rose(currentLimitTrigger))
      else $error("Current limit event does not match a rising trigger.");

   a_fault_event: assert property (
      faultEvent == $rose(faultAbTrigger))
      else $error("Fault AB event does not match a rising trigger.");

   a_event_sets: assert property (
      (eventVec != 2'h0) |=> ((irqStatus & $past(eventVec)) == $past(eventVec)))
      else $error("An event did not set its status bit.");

   a_status_sticky: assert property (
      !irqClearWrite |=> ((irqStatus & $past(irqStatus)) == $past(irqStatus)))
      else $error("A status bit fell without a clear.");

   a_clear_works: assert property (
      (irqClearWrite && eventVec == 2'h0) |=> ((irqStatus & $past(pwdata[`PFS_EVT_W-1:0])) == 2'h0))
      else $error("A clear write left its status bit set.");

   a_irq_raise: assert property (
      (|(irqStatus & irqEnable)) |-> irq)
      else $error("Interrupt low with an enabled status bit set.");

endmodule : pfs_fault_select

// file: src/pfs_defines.svh
// Constants for the second modulator's fault source selection block.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// ============================================================
// Register byte addresses on the APB side.
`define PFS_ADDR_CLIM       32'h0013_0054
`define PFS_ADDR_FAULT      32'h0013_0058
`define PFS_ADDR_IRQ_STATUS 32'h0013_0100
`define PFS_ADDR_IRQ_CLEAR  32'h0013_0104
`define PFS_ADDR_IRQ_ENABLE 32'h0013_0108
`define PFS_ADDR_LIVE       32'h0013_010C

// ============================================================
// Register widths and reset values.
`define PFS_CLIM_W          16
`define PFS_FAULT_W         15
`define PFS_CLIM_RESET      16'h0000
`define PFS_FAULT_RESET     15'h0000

// ============================================================
// Field positions inside the source select registers.
`define PFS_PCM_BIT         15
`define PFS_DCOMP_HI        14
`define PFS_DCOMP_LO        11
`define PFS_EXT_HI          10
`define PFS_EXT_LO          7
`define PFS_ACOMP_HI        6
`define PFS_ACOMP_LO        0

// ============================================================
// Interrupt event layout.
`define PFS_EVT_W           2
`define PFS_EVT_CLIM        0
`define PFS_EVT_FAULT       1
`define PFS_EVT_RESET       2'h0

`endif

// file: src/pfs_pkg.sv
// Types shared by the fault source selection modules.
`include "pfs_defines.svh"

package pfs_pkg;

   // ============================================================
   // Protection sources, packed in the same order as the select bits.
   typedef struct packed {
      logic       analogPeak;
      logic [3:0] digitalComparator;
      logic [3:0] externalFault;
      logic [6:0] analogComparator;
   } pfs_sources_t;

   // ============================================================
   // State of the register bank and its APB slave.
   typedef struct packed {
      logic [`PFS_CLIM_W-1:0]  climReg;
      logic [`PFS_FAULT_W-1:0] faultReg;
      logic                    preadyReg;
      logic                    pslverrReg;
      logic [31:0]             prdataReg;
   } pfs_regs_state_t;

   // State of one source gate.
   typedef struct packed {
      logic trigReg;
      logic eventReg;
   } pfs_gate_state_t;

   // State of the interrupt controller.
   typedef struct packed {
      logic [`PFS_EVT_W-1:0] statusReg;
      logic [`PFS_EVT_W-1:0] enableReg;
      logic                  irqReg;
   } pfs_irq_state_t;

endpackage : pfs_pkg

// file: src/pfs_source_gate.sv
// Gates a vector of protection sources by select bits into one trigger.
`include "pfs_defines.svh"

module pfs_source_gate #(
   parameter int WIDTH = `PFS_CLIM_W
) (
   input  logic             clk_sys,
   input  logic             rst_b,
   input  logic [WIDTH-1:0] sources,
   input  logic [WIDTH-1:0] selects,
   output logic             trigger,
   output logic             risingEvent
);

   pfs_pkg::pfs_gate_state_t stReg;
   pfs_pkg::pfs_gate_state_t stNext;
   logic                     anyHit;

   // ============================================================
   // Trigger is the OR of every selected source; a rising trigger is an event.
   always_comb begin
      anyHit            = |(sources & selects);
      stNext            = stReg;
      stNext.trigReg    = anyHit;
      stNext.eventReg   = anyHit & ~stReg.trigReg;
   end

   // Registering the trigger costs one cycle but gives a glitch-free output.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end

   assign trigger     = stReg.trigReg;
   assign risingEvent = stReg.eventReg;

endmodule : pfs_source_gate

// file: src/pfs_irq_ctrl.sv
// Sticky event status, enable mask and level interrupt output.
`include "pfs_defines.svh"

module pfs_irq_ctrl #(
   parameter int N = `PFS_EVT_W
) (
   input  logic         clk_sys,
   input  logic         rst_b,
   input  logic [N-1:0] events,
   input  logic         enableWrite,
   input  logic         clearWrite,
   input  logic [N-1:0] writeData,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic         irq
);

   pfs_pkg::pfs_irq_state_t stReg;
   pfs_pkg::pfs_irq_state_t stNext;
   logic [N-1:0]            clearMask;

   // ============================================================
   // An event in the clearing cycle survives: the set is ORed in after the clear.
   always_comb begin
      stNext           = stReg;
      clearMask        = clearWrite ? writeData : '0;
      stNext.statusReg = (stReg.statusReg & ~clearMask) | events;
      if (enableWrite) begin
         stNext.enableReg = writeData;
      end
      stNext.irqReg    = |(stNext.statusReg & stNext.enableReg);
   end

   // Irq is computed from next state so it tracks status without extra lag.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end

   assign status = stReg.statusReg;
   assign enable = stReg.enableReg;
   assign irq    = stReg.irqReg;

endmodule : pfs_irq_ctrl

// file: testbench/pfs_source_model.sv
// Behavioural model of the comparators and fault pins that feed the select block.
module pfs_source_model (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   input  wire pfs_pkg::pfs_sources_t  request,
   output pfs_pkg::pfs_sources_t       sources
);
   timeunit 1ns;
   timeprecision 1ps;

   // ============================================================
   // Source levels
   // The comparator outputs are synchronous levels, so a requested pattern shows one edge later.
   // They stay quiet in reset because the real comparators are held there too.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sources <= '0;
      end else begin
         sources <= request;
      end
   end

endmodule : pfs_source_model

// file: testbench/tb.sv
// Self-checking testbench for the fault source select register bank.
`include "pfs_defines.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ============================================================
   // Signals
   logic                  clk_sys;
   logic                  rst_b;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [31:0]           paddr;
   logic [31:0]           pwdata;
   logic [3:0]            pstrb;
   logic                  pready;
   logic [31:0]           prdata;
   logic                  pslverr;
   logic                  currentLimitTrigger;
   logic                  faultAbTrigger;
   logic                  irq;
   pfs_pkg::pfs_sources_t request;
   pfs_pkg::pfs_sources_t sources;
   logic [31:0]           rdVal;
   logic                  errVal;
   logic [15:0]           climVal;
   logic [14:0]           faultVal;
   int                    errors;
   int                    checked;

   // ============================================================
   // Instances
   pfs_fault_select dut (
      .clk_sys             (clk_sys),
      .rst_b               (rst_b),
      .psel                (psel),
      .penable             (penable),
      .pwrite              (pwrite),
      .paddr               (paddr),
      .pwdata              (pwdata),
      .pstrb               (pstrb),
      .pready              (pready),
      .prdata              (prdata),
      .pslverr             (pslverr),
      .sources             (sources),
      .currentLimitTrigger (currentLimitTrigger),
      .faultAbTrigger      (faultAbTrigger),
      .irq                 (irq)
   );

   pfs_source_model model (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .request (request),
      .sources (sources)
   );

   // Clock at 25 MHz.
   initial begin
      clk_sys = 1'b0;
   end
   always #20 clk_sys = ~clk_sys;

   // ============================================================
   // Tasks
   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic results();
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // One APB transfer; the idle edge in front keeps two transfers from assigning psel in one step.
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data, input logic [3:0] strb);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      pstrb <= strb;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Pready, read data and error are taken at the completing edge, before that edge's own updates.
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            errors++;
            results();
         end
         @(posedge clk_sys);
      end
      rdVal = prdata;
      errVal = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads a register and compares it.
   task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000, 4'h0);
      check(rdVal, exp);
   endtask : rd

   // Writes both select registers and keeps the expected copies, bit 15 of the fault copy dropped.
   task automatic wrSel(input logic [15:0] c, input logic [15:0] f);
      apb(1'b1, `PFS_ADDR_CLIM, {16'h0000, c}, 4'h3);
      apb(1'b1, `PFS_ADDR_FAULT, {16'h0000, f}, 4'h3);
      climVal = c;
      faultVal = f[14:0];
   endtask : wrSel

   // Applies a source pattern and checks both triggers after the model and trigger flops.
   task automatic drive(input logic [15:0] v);
      @(posedge clk_sys);
      request <= v;
      repeat (2) @(posedge clk_sys);
      #1;
      check({31'h0, currentLimitTrigger}, {31'h0, |(v & climVal)});
      check({31'h0, faultAbTrigger}, {31'h0, |(v[14:0] & faultVal)});
   endtask : drive

   // ============================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      request = '0;
      errors = 0;
      checked = 0;
      climVal = 16'h0000;
      faultVal = 15'h0000;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      // Reset values and full-width write-back, the unused upper bits reading zero.
      rd(`PFS_ADDR_CLIM, 32'h0000_0000);
      rd(`PFS_ADDR_FAULT, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, `PFS_ADDR_CLIM, 32'hFFFF_FFFF, 4'hF);
      apb(1'b1, `PFS_ADDR_FAULT, 32'hFFFF_FFFF, 4'hF);
      rd(`PFS_ADDR_CLIM, 32'h0000_FFFF);
      rd(`PFS_ADDR_FAULT, 32'h0000_7FFF);
      // A lane without its strobe keeps its old byte.
      apb(1'b1, `PFS_ADDR_CLIM, 32'h0000_0000, 4'h1);
      rd(`PFS_ADDR_CLIM, 32'h0000_FF00);
      // An unmapped place answers with an error and no data.
      apb(1'b1, 32'h0013_0200, 32'hFFFF_FFFF, 4'hF);
      check({31'h0, errVal}, 32'h0000_0001);
      rd(32'h0013_0200, 32'h0000_0000);
      check({31'h0, errVal}, 32'h0000_0001);
      // Each select bit alone: its own source fires, every other source is ignored.
      for (int i = 0; i < 16; i++) begin
         wrSel(16'h0001 << i, 16'h0001 << i);
         drive(16'h0001 << i);
         drive(~(16'h0001 << i));
      end
      // Several selects at once combine by OR.
      wrSel(16'h8881, 16'h4102);
      drive(16'h8000);
      drive(16'h0102);
      drive(16'h0000);
      // Interrupt raised, cleared, masked and unmasked.
      apb(1'b1, `PFS_ADDR_IRQ_CLEAR, 32'h0000_0003, 4'h1);
      apb(1'b1, `PFS_ADDR_IRQ_ENABLE, 32'h0000_0001, 4'h1);
      wrSel(16'h0001, 16'h0002);
      drive(16'h0001);
      @(posedge clk_sys);
      #1;
      check({31'h0, irq}, 32'h0000_0001);
      rd(`PFS_ADDR_IRQ_STATUS, 32'h0000_0001);
      rd(`PFS_ADDR_LIVE, 32'h0000_0001);
      drive(16'h0000);
      apb(1'b1, `PFS_ADDR_IRQ_CLEAR, 32'h0000_0001, 4'h1);
      rd(`PFS_ADDR_IRQ_STATUS, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
      drive(16'h0002);
      @(posedge clk_sys);
      #1;
      check({31'h0, irq}, 32'h0000_0000);
      rd(`PFS_ADDR_IRQ_STATUS, 32'h0000_0002);
      apb(1'b1, `PFS_ADDR_IRQ_ENABLE, 32'h0000_0003, 4'h1);
      #1;
      check({31'h0, irq}, 32'h0000_0001);
      rd(`PFS_ADDR_IRQ_ENABLE, 32'h0000_0003);
      apb(1'b1, `PFS_ADDR_IRQ_CLEAR, 32'h0000_0002, 4'h1);
      #1;
      check({31'h0, irq}, 32'h0000_0000);
      // A second reset in mid-run returns both select registers to zero.
      wrSel(16'hFFFF, 16'hFFFF);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      climVal = 16'h0000;
      faultVal = 15'h0000;
      rd(`PFS_ADDR_CLIM, 32'h0000_0000);
      rd(`PFS_ADDR_FAULT, 32'h0000_0000);
      drive(16'hFFFF);
      results();
   end

endmodule : tb
